// ---- bench/dcsp_host_model.sv ----
// Behavioural SPI host for the configuration serial port.
// Assumes the bench resolves the shared data wire and routes the chosen read pin to rx.
`timescale 1ns/1ps
module dcsp_host_model (
	input wire logic idle_lvl, // Serial clock level between frames.
	input wire logic rx, // Read data from the selected device pin.
	output logic cs_n, // Chip select, active low.
	output logic sclk, // Serial clock, still outside frames.
	output logic dout, // Data driven onto the shared wire.
	output logic doe // High while the host drives the shared wire.
);
	// Power-up state: deselected, clock parked, wire released.
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		dout = 1'b0;
		doe = 1'b0;
	end
	// Chip select on its own, with time for the pin synchronisers to settle.
	task sel(input logic v);
		cs_n = v;
		#80;
	endtask
	// One 16-bit frame, MSB first: data moves in the low half, the device samples on the rising edge.
	task xfer(input logic rd, input logic [6:0] idx, input logic [7:0] wd, output logic [7:0] rdat);
		logic [15:0] sh;
		sh = {rd, idx, wd};
		rdat = 8'h00;
		// Park the clock before selecting, so a change of idle level is never taken as a first edge.
		sclk = idle_lvl;
		#80;
		cs_n = 1'b0;
		#80;
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			doe = !(rd && i < 8);
			dout = sh[i];
			#80;
			sclk = 1'b1;
			if (i < 8)
				rdat[i] = rx;
			#80;
		end
		sclk = idle_lvl;
		doe = 1'b0;
		#40;
		cs_n = 1'b1;
		#120;
	endtask
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the configuration serial port block.
// Assumes a 250 MHz mclk and a host serial clock of 160 ns period.
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {logic idle; logic [7:0] cfg; logic [7:0] dat; logic io; logic so;} dcsp_row_t;
	dcsp_row_t rows [5] = '{'{1'b0, 8'h0c, 8'ha5, 1'b1, 1'b0}, '{1'b1, 8'h0c, 8'h3c, 1'b1, 1'b0},
		'{1'b0, 8'h01, 8'h96, 1'b0, 1'b1}, '{1'b1, 8'h0f, 8'h5a, 1'b0, 1'b0}, '{1'b0, 8'h0e, 8'h81, 1'b1, 1'b0}};
	logic mclk, arst_n, bus_we, bus_re, conv_bus_mode_strap, io_voltage_range_strap, idle, tog, seen_io, seen_so;
	logic [3:0] bus_addr;
	logic [31:0] bus_wdata, d;
	logic [7:0] conv_data_i, r;
	logic [1:0] rx_sel;
	int err_total, tests_run;
	wire [31:0] bus_rdata;
	wire [7:0] conv_data_o, conv_data_oe;
	wire cs_n, cfg_serial_clock, cfg_serial_inout_o, cfg_serial_inout_oe, cfg_serial_out_o, cfg_serial_out_oe;
	wire reference_buffer_en, bandgap_en, h_d, h_oe, rx, cfg_serial_inout_i;
	// A released wire toggles every cycle so stale data can never pass for an answer.
	assign cfg_serial_inout_i = cfg_serial_inout_oe ? cfg_serial_inout_o : (h_oe ? h_d : tog);
	assign rx = rx_sel == 2'h2 ? (conv_data_oe[0] ? conv_data_o[0] : tog) :
		rx_sel == 2'h1 ? (cfg_serial_out_oe ? cfg_serial_out_o : tog) : cfg_serial_inout_i;
	dcsp_top dcsp_top_inst (.mclk, .arst_n, .bus_addr, .bus_wdata, .bus_we, .bus_re, .bus_rdata, .cs_n,
		.cfg_serial_clock, .cfg_serial_inout_i, .cfg_serial_inout_o, .cfg_serial_inout_oe, .cfg_serial_out_o,
		.cfg_serial_out_oe, .conv_bus_mode_strap, .io_voltage_range_strap, .conv_data_i, .conv_data_o,
		.conv_data_oe, .reference_buffer_en, .bandgap_en);
	dcsp_host_model dcsp_host_model_inst (.idle_lvl(idle), .rx(rx), .cs_n(cs_n), .sclk(cfg_serial_clock),
		.dout(h_d), .doe(h_oe));
	// Clock generator.
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// Toggle pattern and sticky records of which read pin was driven.
	always @(posedge mclk) begin
		tog <= ~tog;
		if (cfg_serial_inout_oe)
			seen_io <= 1'b1;
		if (cfg_serial_out_oe)
			seen_so <= 1'b1;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		if (err_total == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Register bus cycles; read data is taken in the single cycle where it stands.
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge mclk);
		bus_we <= 1'b1;
		bus_addr <= a;
		bus_wdata <= v;
		@(posedge mclk);
		bus_we <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge mclk);
		bus_re <= 1'b1;
		bus_addr <= a;
		@(posedge mclk);
		bus_re <= 1'b0;
		#1 v = bus_rdata;
	endtask
	task sx(input logic rdn, input logic [6:0] idx, input logic [7:0] wd, output logic [7:0] q);
		dcsp_host_model_inst.xfer(rdn, idx, wd, q);
	endtask
	task do_reset(input logic lvds);
		arst_n <= 1'b0;
		conv_bus_mode_strap <= lvds;
		io_voltage_range_strap <= lvds;
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (10) @(posedge mclk);
	endtask
	// Watchdog, well beyond the expected run of about 40 us.
	initial begin
		#100000;
		err_total++;
		end_sim();
	end
	// Main sequence.
	initial begin
		{bus_we, bus_re, bus_addr, bus_wdata, idle, tog, seen_io, seen_so, rx_sel} = '0;
		{err_total, tests_run} = '0;
		conv_data_i = 8'h3c;
		arst_n = 1'b0;
		do_reset(1'b0);
		rd(4'h0, d); chk(d, 32'h0c);
		rd(4'h4, d); chk(d, 32'h08);
		wr(4'hc, 32'hff); rd(4'hc, d); chk(d, 32'h0);
		foreach (rows[i]) begin
			idle = rows[i].idle;
			wr(4'h0, 32'(rows[i].cfg)); rd(4'h0, d); chk(d, 32'(rows[i].cfg));
			chk(32'({bandgap_en, reference_buffer_en}), 32'(rows[i].cfg[3:2]));
			rx_sel = rows[i].cfg[0] ? (rows[i].cfg[1] ? 2'h2 : 2'h1) : 2'h0;
			sx(1'b0, 7'h02, rows[i].dat, r); rd(4'h8, d); chk(d, 32'(rows[i].dat));
			seen_io = 1'b0;
			seen_so = 1'b0;
			sx(1'b1, 7'h02, 8'h00, r); chk(32'(r), 32'(rows[i].dat));
			chk(32'({seen_io, seen_so}), 32'({rows[i].io, rows[i].so}));
			chk(32'({cfg_serial_inout_oe, cfg_serial_out_oe, conv_data_oe}), 32'h0);
		end
		// Chip-select gating of the conversion bus in CMOS mode.
		dcsp_host_model_inst.sel(1'b0);
		chk(32'(conv_data_oe), 32'hff); chk(32'(conv_data_o[7:1]), 32'(conv_data_i[7:1]));
		rd(4'h4, d); chk(d, 32'h0c);
		dcsp_host_model_inst.sel(1'b1);
		// Second reset in mid-run with the LVDS strap; the serial port must not care.
		do_reset(1'b1);
		rd(4'h4, d); chk(d, 32'h0b);
		rd(4'h0, d); chk(d, 32'h0c);
		dcsp_host_model_inst.sel(1'b0);
		chk(32'(conv_data_oe), 32'ha5);
		dcsp_host_model_inst.sel(1'b1);
		rx_sel = 2'h0;
		idle = 1'b1;
		sx(1'b0, 7'h02, 8'hc3, r); sx(1'b1, 7'h02, 8'h00, r); chk(32'(r), 32'hc3);
		sx(1'b1, 7'h01, 8'h00, r); chk(32'(r), 32'h0f);
		sx(1'b1, 7'h05, 8'h00, r); chk(32'(r), 32'h00);
		sx(1'b0, 7'h00, 8'h00, r); chk(32'({bandgap_en, reference_buffer_en}), 32'h0);
		end_sim();
	end
endmodule

// ---- verilog/dcsp_pkg.sv ----
// Shared constants for the configuration serial port block.
// Assumes a single 250 MHz core clock and an 8-bit configuration register space.
package dcsp_pkg;
	// Local register port byte offsets, one 32-bit word each.
	localparam logic [3:0] DCSP_OFS_CFG = 4'h0;
	localparam logic [3:0] DCSP_OFS_STAT = 4'h4;
	localparam logic [3:0] DCSP_OFS_USER = 4'h8;
	// Serial-side register indexes.
	localparam logic [6:0] DCSP_IDX_CFG = 7'h00;
	localparam logic [6:0] DCSP_IDX_STAT = 7'h01;
	localparam logic [6:0] DCSP_IDX_USER = 7'h02;
	// Configuration register fields.
	localparam int DCSP_CFG_FOUR_WIRE = 0;
	localparam int DCSP_CFG_CH0_READ = 1;
	localparam int DCSP_CFG_REF_BUF_EN = 2;
	localparam int DCSP_CFG_BANDGAP_EN = 3;
	localparam logic [7:0] DCSP_CFG_RST = 8'h0c;
	localparam logic [7:0] DCSP_USER_RST = 8'h00;
	// Status register fields.
	localparam int DCSP_STAT_LVDS = 0;
	localparam int DCSP_STAT_IO_RANGE = 1;
	localparam int DCSP_STAT_CS = 2;
	localparam int DCSP_STAT_READY = 3;
	// Serial frame: one direction bit, seven address bits, eight data bits.
	localparam logic [4:0] DCSP_HDR_BITS = 5'h08;
	localparam logic [4:0] DCSP_FRAME_BITS = 5'h10;
	// Cycles after reset release before the straps are trusted; the synchroniser needs four to settle.
	localparam logic [2:0] DCSP_STRAP_WAIT = 3'h5;
	// Conversion outputs that go high-impedance in LVDS mode.
	localparam logic [7:0] DCSP_LVDS_UNUSED = 8'h5a;
endpackage

// ---- verilog/dcsp_sync3.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk; output changes once stages two and three agree.
`timescale 1ns/1ps
module dcsp_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk, // Core clock.
	input wire logic rst_n, // Synchronised reset, active low.
	input wire logic [W-1:0] din, // Asynchronous inputs.
	output logic [W-1:0] dout // Filtered synchronous levels.
);
	logic [W-1:0] s1_ff, s2_ff, s3_ff, dout_ff;
	logic [W-1:0] nxt_dout;

	// Only the second and third stages feed the filter, so the metastable first stage stays isolated.
	always_comb begin
		nxt_dout = ((s2_ff ~^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & dout_ff);
	end

	// Shift stages and hold the agreed level.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
			dout_ff <= RST_VAL;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			dout_ff <= nxt_dout;
		end
	end

	assign dout = dout_ff;
endmodule

// ---- verilog/dcsp_top.sv ----
// Configuration serial port with chip-select gating of the conversion outputs.
// Assumes pins reach mclk through dcsp_sync3 and the serial clock is far slower than mclk.
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module dcsp_top
	import dcsp_pkg::*;
#(
	parameter int NCH = 8
) (
	input wire logic mclk, // Core clock, 250 MHz.
	input wire logic arst_n, // Asynchronous reset, active low.
	input wire logic [3:0] bus_addr, // Local register byte address.
	input wire logic [31:0] bus_wdata, // Local write data.
	input wire logic bus_we, // Local write strobe.
	input wire logic bus_re, // Local read strobe.
	output logic [31:0] bus_rdata, // Read data, valid the cycle after bus_re.
	input wire logic cs_n, // Chip select pin, active low.
	input wire logic cfg_serial_clock, // Configuration serial clock pin.
	input wire logic cfg_serial_inout_i, // Bidirectional data pin, input side.
	output logic cfg_serial_inout_o, // Bidirectional data pin, output side.
	output logic cfg_serial_inout_oe, // Bidirectional data pin enable.
	output logic cfg_serial_out_o, // Dedicated configuration data output.
	output logic cfg_serial_out_oe, // Dedicated output enable.
	input wire logic conv_bus_mode_strap, // High selects LVDS conversion output.
	input wire logic io_voltage_range_strap, // Supply range strap, reported only.
	input wire logic [NCH-1:0] conv_data_i, // Conversion bits from the converter core.
	output logic [NCH-1:0] conv_data_o, // Conversion data output pins.
	output logic [NCH-1:0] conv_data_oe, // Conversion data output enables.
	output logic reference_buffer_en, // Internal reference buffer enable.
	output logic bandgap_en // Internal band-gap enable.
);
	logic rst_s1_ff, rst_n_ff;
	logic cs_f, sck_f, din_f, lvds_f, iorng_f;
	logic sck_d_ff, sck_rise, sck_fall, cs_act, spi_wr;
	logic [4:0] cnt_ff, nxt_cnt;
	logic [6:0] shin_ff, nxt_shin, addr_ff, nxt_addr;
	logic rd_ff, nxt_rd, rdact_ff, nxt_rdact, dout_ff, nxt_dout;
	logic [7:0] rdval_ff, nxt_rdval, cfg_ff, nxt_cfg, user_ff, nxt_user, spi_data;
	logic lvds_ff, nxt_lvds, iorng_ff, nxt_iorng;
	logic [2:0] wait_ff, nxt_wait;
	logic [31:0] nxt_rdata;
	logic nxt_io_oe, nxt_so_oe;
	logic [NCH-1:0] nxt_cd_o, nxt_cd_oe;

	// Reset release passes two flip-flops so every process leaves reset on the same edge.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n_ff <= rst_s1_ff;
		end
	end

	// All pins are asynchronous; chip select resets to its inactive level.
	dcsp_sync3 #(.W(5), .RST_VAL(5'h10)) u_sync (
		.clk(mclk),
		.rst_n(rst_n_ff),
		.din({cs_n, cfg_serial_clock, cfg_serial_inout_i, conv_bus_mode_strap, io_voltage_range_strap}),
		.dout({cs_f, sck_f, din_f, lvds_f, iorng_f})
	);

	// Edges only count while selected, so a parked clock of either level starts no frame.
	assign cs_act = ~cs_f;
	assign sck_rise = cs_act & sck_f & ~sck_d_ff;
	assign sck_fall = cs_act & ~sck_f & sck_d_ff;
	assign spi_wr = sck_rise & (cnt_ff == DCSP_FRAME_BITS - 5'h01) & ~rd_ff;
	assign spi_data = {shin_ff, din_f};

	// Register read mux shared by the serial port and the local port.
	function automatic logic [7:0] reg_rd(input logic [6:0] idx, input logic [7:0] cfg, input logic [7:0] usr,
		input logic [3:0] st);
		case (idx)
			DCSP_IDX_CFG: reg_rd = cfg;
			DCSP_IDX_STAT: reg_rd = {4'h0, st};
			DCSP_IDX_USER: reg_rd = usr;
			default: reg_rd = 8'h00;
		endcase
	endfunction

	logic [3:0] stat;
	assign stat = {(wait_ff == DCSP_STRAP_WAIT), cs_act, iorng_ff, lvds_ff};

	// Serial frame engine; the strap never enters it, so access is the same in both bus modes.
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_shin = shin_ff;
		nxt_addr = addr_ff;
		nxt_rd = rd_ff;
		nxt_rdact = rdact_ff;
		nxt_dout = dout_ff;
		nxt_rdval = rdval_ff;
		if (!cs_act) begin
			nxt_cnt = 5'h00;
			nxt_rd = 1'b0;
			nxt_rdact = 1'b0;
		end else if (sck_rise && cnt_ff < DCSP_FRAME_BITS) begin
			nxt_cnt = cnt_ff + 5'h01;
			nxt_shin = {shin_ff[5:0], din_f};
			if (cnt_ff == DCSP_HDR_BITS - 5'h01) begin
				nxt_rd = shin_ff[6];
				nxt_addr = {shin_ff[5:0], din_f};
				nxt_rdval = reg_rd({shin_ff[5:0], din_f}, cfg_ff, user_ff, stat);
			end
		end else if (sck_fall && rd_ff && cnt_ff >= DCSP_HDR_BITS && cnt_ff < DCSP_FRAME_BITS) begin
			// Data changes on falling edges so the host samples it stable on the next rising edge.
			nxt_rdact = 1'b1;
			nxt_dout = rdval_ff[3'(5'h0f - cnt_ff)];
		end
	end

	// Settings written from the serial port win over the local port in the same cycle.
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_user = user_ff;
		if (bus_we && bus_addr == DCSP_OFS_CFG) nxt_cfg = bus_wdata[7:0];
		if (bus_we && bus_addr == DCSP_OFS_USER) nxt_user = bus_wdata[7:0];
		if (spi_wr && addr_ff == DCSP_IDX_CFG) nxt_cfg = spi_data;
		if (spi_wr && addr_ff == DCSP_IDX_USER) nxt_user = spi_data;
		nxt_rdata = 32'h0;
		// Unaligned byte addresses read zero instead of aliasing onto a register.
		if (bus_re && bus_addr[1:0] == 2'h0) nxt_rdata = {24'h0, reg_rd(7'(bus_addr[3:2]), cfg_ff, user_ff, stat)};
	end

	// Straps are captured once after reset, when the synchroniser has settled.
	always_comb begin
		nxt_wait = wait_ff;
		nxt_lvds = lvds_ff;
		nxt_iorng = iorng_ff;
		if (wait_ff != DCSP_STRAP_WAIT) begin
			nxt_wait = wait_ff + 3'h1;
			nxt_lvds = lvds_f;
			nxt_iorng = iorng_f;
		end
	end

	// Pin drivers; every enable is dropped while chip select is high.
	always_comb begin
		nxt_io_oe = cs_act & rdact_ff & ~cfg_ff[DCSP_CFG_FOUR_WIRE];
		nxt_so_oe = cs_act & rdact_ff & cfg_ff[DCSP_CFG_FOUR_WIRE] & ~cfg_ff[DCSP_CFG_CH0_READ];
		nxt_cd_o = conv_data_i;
		nxt_cd_oe = {NCH{cs_act}} & ~({NCH{lvds_ff}} & NCH'(DCSP_LVDS_UNUSED));
		if (cs_act && rdact_ff && cfg_ff[DCSP_CFG_FOUR_WIRE] && cfg_ff[DCSP_CFG_CH0_READ]) begin
			nxt_cd_o[0] = dout_ff;
			nxt_cd_oe[0] = 1'b1;
		end
	end

	// Register every state and output group.
	always_ff @(posedge mclk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			sck_d_ff <= 1'b0;
			cnt_ff <= 5'h00;
			shin_ff <= 7'h00;
			addr_ff <= 7'h00;
			rd_ff <= 1'b0;
			rdact_ff <= 1'b0;
			dout_ff <= 1'b0;
			rdval_ff <= 8'h00;
			cfg_ff <= DCSP_CFG_RST;
			user_ff <= DCSP_USER_RST;
			wait_ff <= 3'h0;
			lvds_ff <= 1'b0;
			iorng_ff <= 1'b0;
			bus_rdata <= 32'h0;
			cfg_serial_inout_o <= 1'b0;
			cfg_serial_inout_oe <= 1'b0;
			cfg_serial_out_o <= 1'b0;
			cfg_serial_out_oe <= 1'b0;
			conv_data_o <= '0;
			conv_data_oe <= '0;
			reference_buffer_en <= 1'b0;
			bandgap_en <= 1'b0;
		end else begin
			sck_d_ff <= sck_f;
			cnt_ff <= nxt_cnt;
			shin_ff <= nxt_shin;
			addr_ff <= nxt_addr;
			rd_ff <= nxt_rd;
			rdact_ff <= nxt_rdact;
			dout_ff <= nxt_dout;
			rdval_ff <= nxt_rdval;
			cfg_ff <= nxt_cfg;
			user_ff <= nxt_user;
			wait_ff <= nxt_wait;
			lvds_ff <= nxt_lvds;
			iorng_ff <= nxt_iorng;
			bus_rdata <= nxt_rdata;
			cfg_serial_inout_o <= dout_ff;
			cfg_serial_inout_oe <= nxt_io_oe;
			cfg_serial_out_o <= dout_ff;
			cfg_serial_out_oe <= nxt_so_oe;
			conv_data_o <= nxt_cd_o;
			conv_data_oe <= nxt_cd_oe;
			reference_buffer_en <= cfg_ff[DCSP_CFG_REF_BUF_EN];
			bandgap_en <= cfg_ff[DCSP_CFG_BANDGAP_EN];
		end
	end

	// Checks on pin behaviour and settings.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n_ff);

	sequence s_read_on;
		cs_act && rdact_ff;
	endsequence
	sequence s_four_dedicated;
		cfg_ff[DCSP_CFG_FOUR_WIRE] && !cfg_ff[DCSP_CFG_CH0_READ];
	endsequence

	AST_CS_HIZ: assert property (!cs_act |=> !cfg_serial_inout_oe && !cfg_serial_out_oe && conv_data_oe == '0)
		else $error("Output enabled while chip select high.");
	AST_3W_SO_HIZ: assert property (!cfg_ff[DCSP_CFG_FOUR_WIRE] |=> !cfg_serial_out_oe)
		else $error("Dedicated output driven in 3-wire form.");
	AST_4W_DRIVE: assert property (s_read_on and s_four_dedicated |=> cfg_serial_out_oe && !cfg_serial_inout_oe)
		else $error("4-wire read not on dedicated output.");
	AST_3W_DRIVE: assert property (s_read_on and !cfg_ff[DCSP_CFG_FOUR_WIRE] |=> cfg_serial_inout_oe)
		else $error("3-wire read not on bidirectional pin.");
	AST_CH0_ROUTE: assert property (s_read_on and cfg_ff[DCSP_CFG_FOUR_WIRE] && cfg_ff[DCSP_CFG_CH0_READ]
		|=> conv_data_oe[0] && conv_data_o[0] == $past(dout_ff) && !cfg_serial_out_oe)
		else $error("Channel-zero read route wrong.");
	AST_LVDS_HIZ: assert property (lvds_ff |=> (conv_data_oe & NCH'(DCSP_LVDS_UNUSED)) == '0)
		else $error("Unused CMOS output driven in LVDS mode.");
	AST_STRAP_HOLD: assert property (wait_ff == DCSP_STRAP_WAIT && $past(wait_ff) == DCSP_STRAP_WAIT
		|-> $stable(lvds_ff))
		else $error("Bus mode changed after capture.");
	AST_SPI_WRITE: assert property (spi_wr && addr_ff == DCSP_IDX_CFG |=> cfg_ff == $past(spi_data))
		else $error("Serial write lost.");
	AST_IDLE_CLEAR: assert property (!cs_act |=> cnt_ff == 5'h00 && !rdact_ff)
		else $error("Frame state kept across deselect.");
	AST_DEF_3W: assert property ($rose(rst_n_ff) |-> !cfg_ff[DCSP_CFG_FOUR_WIRE])
		else $error("Reset default not 3-wire.");
endmodule
